// ==== design/irq_pkg.sv ====
package irq_pkg;

	// Register byte offsets on the bus
	localparam logic [7:0] MASK_LOWER_OFF = 8'h00;
	localparam logic [7:0] MASK_UPPER_OFF = 8'h04;
	localparam logic [7:0] STEER_LOWER_OFF = 8'h08;
	localparam logic [7:0] IRQ_PEND_LOWER_OFF = 8'h0C;
	localparam logic [7:0] FIQ_PEND_LOWER_OFF = 8'h10;
	localparam logic [7:0] IRQ_PEND_UPPER_OFF = 8'h14;
	localparam logic [7:0] FIQ_PEND_UPPER_OFF = 8'h18;
	localparam logic [7:0] PRIO_UPPER_OFF = 8'h1C;
	localparam logic [7:0] WD_CTRL_OFF = 8'h20;
	localparam logic [7:0] WD_LOAD_OFF = 8'h24;
	localparam logic [7:0] EVT_STATUS_OFF = 8'h28;
	localparam logic [7:0] EVT_MASK_OFF = 8'h2C;
	localparam logic [7:0] STEER_UPPER_OFF = 8'h30;

	// Field positions
	localparam int DMA0_DONE_BIT = 0;
	localparam int WD_BIT = 17;
	localparam int HIGH_PRIO_BIT = 31;
	localparam int EXT_FIRST_BIT = 27;
	localparam int WD_PRIO_LSB = 2;
	localparam int EVT_WD_BIT = 0;
	localparam int EVT_RESET_BIT = 1;

	// Watchdog unlock words, written in order to enable
	localparam logic [31:0] WD_KEY_FIRST = 32'h1E1E_1E1E;
	localparam logic [31:0] WD_KEY_SECOND = 32'hE1E1_E1E1;

	// Reset values
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [31:0] WD_LOAD_RESET = 32'h0000_FFFF;
	localparam logic [7:0] CHIP_RESET_CYCLES = 8'h10;

	typedef enum logic [1:0] {WD_OFF, WD_ARMED, WD_RUN} wd_state_type;

endpackage

// ==== design/wd_if.sv ====
`timescale 1ns/1ns
// Signals between the controller and its watchdog counter
interface wd_if;
	logic enable;
	logic [31:0] load;
	logic kick;
	logic expire;

	modport ctrl (output enable, output load, output kick, input expire);
	modport counter (input enable, input load, input kick, output expire);
endinterface

// ==== design/wd_counter.sv ====
`timescale 1ns/1ns
module wd_counter
(
	input wire logic clk,
	input wire logic rst,
	wd_if.counter wd
);
	typedef struct packed
	{
		logic [31:0] count;
		logic expire;
	} cnt_state_type;

	cnt_state_type s_q;
	cnt_state_type s_d;

	// Count down while enabled; expiry is a single pulse, with the reload on the same edge
	always_comb
	begin
		s_d = s_q;
		s_d.expire = 1'b0;
		if (!wd.enable || wd.kick)
			s_d.count = wd.load;
		else if (s_q.count == 32'h0000_0000)
		begin
			s_d.expire = 1'b1;
			s_d.count = wd.load;
		end
		else
			s_d.count = s_q.count - 32'h0000_0001;
	end

	// Registered state
	always_ff @(posedge clk)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign wd.expire = s_q.expire;

	// A disabled counter never expires
	no_idle_expiry_a: assert property (@(posedge clk) disable iff (rst)
		!$past(wd.enable) |-> !wd.expire)
		else $error("watchdog expired while disabled");
endmodule

// ==== design/ahb_slave.sv ====
`timescale 1ns/1ns
// Zero-wait AHB-Lite front end producing one-cycle register strobes
module ahb_slave
(
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	output logic wr_stb,
	output logic rd_stb,
	output logic [7:0] addr
);
	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [7:0] addr;
	} ph_state_type;

	ph_state_type s_q;
	ph_state_type s_d;

	// Capture a valid address phase; strobe fires in its data phase
	always_comb
	begin
		s_d = s_q;
		s_d.wr = 1'b0;
		s_d.rd = 1'b0;
		if (hsel && hready && htrans[1])
		begin
			s_d.wr = hwrite;
			s_d.rd = !hwrite;
			s_d.addr = haddr[7:0];
		end
	end

	// Registered phase
	always_ff @(posedge clk)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign wr_stb = s_q.wr;
	assign rd_stb = s_q.rd;
	assign addr = s_q.addr;
endmodule

// ==== design/irq_wd_ctrl.sv ====
`timescale 1ns/1ns
module irq_wd_ctrl
(
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic [31:0] SRC_LOWER,
	input wire logic [3:0] SEC_IRQ_N,
	input wire logic HIGH_PRIORITY_IRQ_INPUT_N,
	output logic CORE_IRQ,
	output logic CORE_FIQ,
	output logic CHIP_RESET,
	output logic EVENT_IRQ
);
	typedef struct packed
	{
		logic [31:0] mask_lo;
		logic [31:0] mask_up;
		logic [31:0] steer_lo;
		logic [31:0] steer_up;
		logic [31:0] prio_up;
		logic [31:0] wd_load;
		logic [1:0] evt_status;
		logic [1:0] evt_mask;
		logic wd_latch;
		irq_pkg::wd_state_type wd_state;
		logic [7:0] rst_cnt;
		logic [31:0] rdata;
		logic irq;
		logic fiq;
		logic chip_rst;
		logic evt_irq;
	} ctl_state_type;

	ctl_state_type s_q;
	ctl_state_type s_d;
	logic wr_stb;
	logic rd_stb;
	logic [7:0] reg_addr;
	logic [31:0] raw_lo;
	logic [31:0] raw_up;
	logic [31:0] act_lo;
	logic [31:0] act_up;
	logic [4:0] ext_n;
	logic [4:0] ext_req;

	wd_if wd ();

	ahb_slave bus
	(
		.clk(CORE_CLK),
		.rst(RST),
		.hsel(HSEL),
		.haddr(HADDR),
		.htrans(HTRANS),
		.hwrite(HWRITE),
		.hready(HREADY),
		.wr_stb(wr_stb),
		.rd_stb(rd_stb),
		.addr(reg_addr)
	);

	wd_counter wdc
	(
		.clk(CORE_CLK),
		.rst(RST),
		.wd(wd)
	);

	// One identical request path per external input; the high-priority
	// input is only the top lane, so it can never overtake the others
	assign ext_n = {HIGH_PRIORITY_IRQ_INPUT_N, SEC_IRQ_N};
	generate
		for (genvar g = 0; g < 5; g++)
		begin : ext_path
			assign ext_req[g] = !ext_n[g];
		end
	endgenerate

	// External request bits share one path, no bypass for priority
	always_comb
	begin
		raw_lo = SRC_LOWER;
		raw_lo[irq_pkg::WD_BIT] = s_q.wd_latch;
		raw_up = 32'h0000_0000;
		raw_up[irq_pkg::EXT_FIRST_BIT +: 5] = ext_req;
	end

	// Masking gates every source the same way
	assign act_lo = raw_lo & s_q.mask_lo;
	assign act_up = raw_up & s_q.mask_up;

	assign wd.enable = (s_q.wd_state == irq_pkg::WD_RUN);
	assign wd.load = s_q.wd_load;
	assign wd.kick = wr_stb && reg_addr == irq_pkg::WD_CTRL_OFF
		&& s_q.wd_state == irq_pkg::WD_RUN;

	// Next state: bus writes, watchdog sequence, outcome, outputs
	always_comb
	begin
		s_d = s_q;
		if (wr_stb)
		begin
			unique case (reg_addr)
				irq_pkg::MASK_LOWER_OFF: s_d.mask_lo = HWDATA;
				irq_pkg::MASK_UPPER_OFF: s_d.mask_up = HWDATA;
				irq_pkg::STEER_LOWER_OFF: s_d.steer_lo = HWDATA;
				irq_pkg::STEER_UPPER_OFF: s_d.steer_up = HWDATA;
				irq_pkg::PRIO_UPPER_OFF: s_d.prio_up = HWDATA;
				irq_pkg::WD_LOAD_OFF: s_d.wd_load = HWDATA;
				irq_pkg::EVT_MASK_OFF: s_d.evt_mask = HWDATA[1:0];
				irq_pkg::EVT_STATUS_OFF:
					s_d.evt_status = s_q.evt_status & ~HWDATA[1:0];
				irq_pkg::IRQ_PEND_LOWER_OFF,
				irq_pkg::FIQ_PEND_LOWER_OFF:
					if (HWDATA[irq_pkg::WD_BIT])
						s_d.wd_latch = 1'b0;
				default:;
			endcase
		end
		// Enabling sequence: two keys in order, anything else drops back
		if (wr_stb && reg_addr == irq_pkg::WD_CTRL_OFF)
		begin
			unique case (s_q.wd_state)
				irq_pkg::WD_OFF:
					if (HWDATA == irq_pkg::WD_KEY_FIRST)
						s_d.wd_state = irq_pkg::WD_ARMED;
				irq_pkg::WD_ARMED:
					s_d.wd_state = (HWDATA == irq_pkg::WD_KEY_SECOND)
						? irq_pkg::WD_RUN : irq_pkg::WD_OFF;
				irq_pkg::WD_RUN:;
				default: s_d.wd_state = irq_pkg::WD_OFF;
			endcase
		end
		// Count down first, so a fresh expiry below restarts a full pulse
		if (s_q.rst_cnt != 8'h00)
			s_d.rst_cnt = s_q.rst_cnt - 8'h01;
		// Expiry takes exactly one outcome; set wins over software clear
		if (wd.expire)
		begin
			if (s_q.mask_lo[irq_pkg::WD_BIT])
				s_d.wd_latch = 1'b1;
			else
				s_d.rst_cnt = irq_pkg::CHIP_RESET_CYCLES;
			s_d.evt_status[irq_pkg::EVT_WD_BIT] = 1'b1;
		end
		if (s_q.rst_cnt == irq_pkg::CHIP_RESET_CYCLES)
			s_d.evt_status[irq_pkg::EVT_RESET_BIT] = 1'b1;
		s_d.chip_rst = (s_d.rst_cnt != 8'h00);
		// Steering: set bit routes to FIQ, clear to IRQ
		s_d.irq = |(act_lo & ~s_q.steer_lo) || |(act_up & ~s_q.steer_up);
		s_d.fiq = |(act_lo & s_q.steer_lo) || |(act_up & s_q.steer_up);
		s_d.evt_irq = |(s_d.evt_status & s_d.evt_mask);
		// Read mux, registered so answer is ready in the data phase
		s_d.rdata = 32'h0000_0000;
		unique case (HADDR[7:0])
			irq_pkg::MASK_LOWER_OFF: s_d.rdata = s_q.mask_lo;
			irq_pkg::MASK_UPPER_OFF: s_d.rdata = s_q.mask_up;
			irq_pkg::STEER_LOWER_OFF: s_d.rdata = s_q.steer_lo;
			irq_pkg::STEER_UPPER_OFF: s_d.rdata = s_q.steer_up;
			irq_pkg::IRQ_PEND_LOWER_OFF:
				s_d.rdata = act_lo & ~s_q.steer_lo;
			irq_pkg::FIQ_PEND_LOWER_OFF:
				s_d.rdata = act_lo & s_q.steer_lo;
			irq_pkg::IRQ_PEND_UPPER_OFF: s_d.rdata = act_up & ~s_q.steer_up;
			irq_pkg::FIQ_PEND_UPPER_OFF: s_d.rdata = act_up & s_q.steer_up;
			irq_pkg::PRIO_UPPER_OFF: s_d.rdata = s_q.prio_up;
			irq_pkg::WD_CTRL_OFF:
				s_d.rdata = {30'h0000_0000, s_q.wd_state};
			irq_pkg::WD_LOAD_OFF: s_d.rdata = s_q.wd_load;
			irq_pkg::EVT_STATUS_OFF:
				s_d.rdata = {30'h0000_0000, s_q.evt_status};
			irq_pkg::EVT_MASK_OFF:
				s_d.rdata = {30'h0000_0000, s_q.evt_mask};
			default: s_d.rdata = 32'h0000_0000;
		endcase
	end

	// All masks clear at reset, so every source starts masked
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			s_q <= '0;
			s_q.wd_load <= irq_pkg::WD_LOAD_RESET;
			s_q.wd_state <= irq_pkg::WD_OFF;
		end
		else
			s_q <= s_d;
	end

	// Always zero-wait and OKAY; unmapped reads return zero
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign HRDATA = s_q.rdata;
	assign CORE_IRQ = s_q.irq;
	assign CORE_FIQ = s_q.fiq;
	assign CHIP_RESET = s_q.chip_rst;
	assign EVENT_IRQ = s_q.evt_irq;

	// Checks on masking, the shared request path and the watchdog outcome;
	// outputs are registered, so most consequents look one edge later
	high_prio_masked_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) !s_q.mask_up[31] && !s_q.steer_up[31]
		&& s_q.mask_up[30:27] == 4'h0 && s_q.mask_lo == 32'h0000_0000
		|=> !CORE_IRQ)
		else $error("masked high-priority input raised IRQ");

	upper_mask_bit_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) wr_stb && reg_addr == irq_pkg::MASK_UPPER_OFF
		|=> s_q.mask_up[31] == $past(HWDATA[31]))
		else $error("upper mask bit 31 not written");

	wd_reset_path_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) wd.expire && !s_q.mask_lo[17]
		|=> ##1 CHIP_RESET)
		else $error("expiry with bit clear did not reset chip");

	wd_irq_path_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) wd.expire && s_q.mask_lo[17] |=> s_q.wd_latch)
		else $error("expiry with bit set did not pend");

	one_outcome_only_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) wd.expire && s_q.mask_lo[17] && !CHIP_RESET
		&& s_q.rst_cnt == 8'h00 |=> ##1 !CHIP_RESET)
		else $error("interrupt expiry also reset chip");

	wd_off_idle_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) s_q.wd_state != irq_pkg::WD_RUN
		|=> !wd.expire)
		else $error("watchdog expired before enabling");

	masked_not_pending_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) rd_stb && reg_addr == irq_pkg::IRQ_PEND_LOWER_OFF
		&& !$past(s_q.mask_lo[0]) |-> !HRDATA[0])
		else $error("masked source read as pending");

	wd_pend_sticky_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) s_q.wd_latch && !wr_stb |=> s_q.wd_latch)
		else $error("watchdog pending bit lost");

	same_path_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) s_q.mask_up[31] && !s_q.steer_up[31]
		&& !HIGH_PRIORITY_IRQ_INPUT_N |=> CORE_IRQ)
		else $error("unmasked high-priority input ignored");

	hp_to_fiq_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) s_q.mask_up[31] && s_q.steer_up[31]
		&& !HIGH_PRIORITY_IRQ_INPUT_N |=> CORE_FIQ)
		else $error("unmasked high-priority input missed FIQ");

	sec_to_irq_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) s_q.mask_up[28] && !s_q.steer_up[28]
		&& !SEC_IRQ_N[1] |=> CORE_IRQ)
		else $error("unmasked secondary request ignored");

	hp_pend_masked_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) rd_stb && reg_addr == irq_pkg::IRQ_PEND_UPPER_OFF
		&& !$past(s_q.mask_up[31]) |-> !HRDATA[31])
		else $error("masked high-priority input read as pending");

	mask_readback_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) rd_stb && reg_addr == irq_pkg::MASK_UPPER_OFF
		|-> HRDATA == $past(s_q.mask_up))
		else $error("upper mask read back wrong");

	quiet_after_mask_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) s_q.mask_lo == 32'h0000_0000
		&& s_q.mask_up == 32'h0000_0000 |=> !CORE_IRQ && !CORE_FIQ)
		else $error("interrupt raised with every source masked");

	chip_reset_start_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) $rose(CHIP_RESET)
		|-> s_q.rst_cnt == irq_pkg::CHIP_RESET_CYCLES)
		else $error("chip reset began without a full count");

	chip_reset_end_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) s_q.rst_cnt == 8'h01 && !wd.expire
		|=> !CHIP_RESET)
		else $error("chip reset outlasted its count");

	expiry_logged_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) wd.expire |=> s_q.evt_status[irq_pkg::EVT_WD_BIT])
		else $error("expiry not logged in event status");

	irq_no_reset_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) wd.expire && s_q.mask_lo[17]
		&& s_q.rst_cnt == 8'h00 |=> s_q.rst_cnt == 8'h00)
		else $error("interrupt expiry started a chip reset");

	reset_no_irq_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) wd.expire && !s_q.mask_lo[17] && !s_q.wd_latch
		|=> !s_q.wd_latch)
		else $error("reset expiry also pended an interrupt");

	wd_to_fiq_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) s_q.wd_latch && s_q.mask_lo[17]
		&& s_q.steer_lo[17] |=> CORE_FIQ)
		else $error("steered watchdog interrupt missed FIQ");

	prio_field_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) wr_stb && reg_addr == irq_pkg::PRIO_UPPER_OFF
		|=> s_q.prio_up[3:2] == $past(HWDATA[3:2]))
		else $error("watchdog priority field not stored");

	key_order_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) s_q.wd_state == irq_pkg::WD_OFF
		|=> s_q.wd_state != irq_pkg::WD_RUN)
		else $error("watchdog started without both keys");

	fiq_masked_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) rd_stb && reg_addr == irq_pkg::FIQ_PEND_LOWER_OFF
		&& !$past(s_q.mask_lo[0]) |-> !HRDATA[0])
		else $error("masked source read as FIQ pending");

	wd_clear_a: assert property (@(posedge CORE_CLK)
		disable iff (RST) wr_stb && reg_addr == irq_pkg::FIQ_PEND_LOWER_OFF
		&& HWDATA[17] && !wd.expire |=> !s_q.wd_latch)
		else $error("watchdog pending bit not cleared");
endmodule

// ==== verification/core_model.sv ====
`timescale 1ns/1ns
// Processor core stand-in: counts interrupt entries
module core_model
(
	input wire logic clk,
	input wire logic rst,
	input wire logic irq,
	input wire logic fiq,
	output int irq_n,
	output int fiq_n
);
	logic irq_q;
	logic fiq_q;

	// A level that stays up is one entry, so count rising levels only
	always @(posedge clk)
	begin
		if (rst)
		begin
			irq_q <= 1'b0;
			fiq_q <= 1'b0;
			irq_n <= 0;
			fiq_n <= 0;
		end
		else
		begin
			irq_q <= irq;
			fiq_q <= fiq;
			irq_n <= irq_n + int'(irq && !irq_q);
			fiq_n <= fiq_n + int'(fiq && !fiq_q);
		end
	end
endmodule

// ==== verification/watchdog_and_priority_irq_masking_test.sv ====
`timescale 1ns/1ns
module watchdog_and_priority_irq_masking_test;
	logic CORE_CLK = 0;
	logic RST = 1;
	logic HSEL = 0;
	logic HWRITE = 0;
	logic [1:0] HTRANS = 0;
	logic [31:0] HADDR = 0;
	logic [31:0] HWDATA = 0;
	logic [31:0] SRC_LOWER = 0;
	logic [3:0] SEC_IRQ_N = 4'hF;
	logic HIGH_PRIORITY_IRQ_INPUT_N = 1;
	logic [31:0] HRDATA;
	logic HREADYOUT, HRESP, CORE_IRQ, CORE_FIQ, CHIP_RESET, EVENT_IRQ;
	logic rd_ph = 0;
	logic [31:0] exp_q[$];
	logic [31:0] b, m, s, r;
	int num_errors = 0;
	int checked = 0;
	int k, irq_n, fiq_n, f0, i0;

	always #20 CORE_CLK = ~CORE_CLK;

	irq_wd_ctrl i_irq_wd_ctrl (.CORE_CLK(CORE_CLK), .RST(RST), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
		.HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .SRC_LOWER(SRC_LOWER),
		.SEC_IRQ_N(SEC_IRQ_N),
		.HIGH_PRIORITY_IRQ_INPUT_N(HIGH_PRIORITY_IRQ_INPUT_N),
		.CORE_IRQ(CORE_IRQ), .CORE_FIQ(CORE_FIQ), .CHIP_RESET(CHIP_RESET),
		.EVENT_IRQ(EVENT_IRQ));

	core_model i_core_model (.clk(CORE_CLK), .rst(RST), .irq(CORE_IRQ),
		.fiq(CORE_FIQ), .irq_n(irq_n), .fiq_n(fiq_n));

	// Comparison, counting and closing report
	task chk(input logic [31:0] v, input logic [31:0] e);
		checked++;
		if (v !== e)
		begin
			num_errors++;
			$display("Error %0t: saw %h, expected %h", $time, v, e);
		end
	endtask

	task print_verdict;
		$display("checks %0d, errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task tmo;
		num_errors++;
		$display("Error %0t: wait ran out", $time);
		print_verdict;
	endtask

	// Bounded wait for hready, never trusting a fixed latency
	task rdy;
		int n;
		for (n = 0; n < 9; n++)
		begin
			@(posedge CORE_CLK);
			if (HREADYOUT === 1'b1)
				break;
		end
		if (n == 9)
			tmo;
	endtask

	// One single AHB transfer: address phase, then data phase
	task acc(input logic [7:0] a, input logic w, input logic [31:0] d);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= {24'h0, a};
		HWRITE <= w;
		rdy;
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		rdy;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		acc(a, 1'b1, d);
	endtask

	// Expected read data is queued before the address phase goes out
	task rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		acc(a, 1'b0, 32'h0);
	endtask

	// Bounded wait for CORE_FIQ (sel 1) or CHIP_RESET (sel 0) to reach v
	task wt(input logic sel, input logic v);
		for (k = 0; k < 300; k++)
		begin
			@(posedge CORE_CLK);
			#1;
			if ((sel ? CORE_FIQ : CHIP_RESET) === v)
				break;
		end
		if (k == 300)
			tmo;
	endtask

	// Read monitor: data taken at the edge that closes the data phase
	always @(posedge CORE_CLK)
	begin
		if (rd_ph)
		begin
			chk(HRDATA, exp_q.pop_front());
			chk({31'h0, HRESP}, 32'h0);
		end
		rd_ph <= HSEL && HTRANS[1] && !HWRITE && HREADYOUT;
	end

	initial
	begin
		void'($urandom(29495));
		repeat (2) @(posedge CORE_CLK);
		RST <= 1'b0;
		#1;
		chk({28'h0, CORE_IRQ, CORE_FIQ, CHIP_RESET, EVENT_IRQ}, 32'h0);
		HIGH_PRIORITY_IRQ_INPUT_N <= 1'b0;
		SEC_IRQ_N <= 4'h0;
		rd(irq_pkg::MASK_UPPER_OFF, 32'h0);
		rd(irq_pkg::IRQ_PEND_UPPER_OFF, 32'h0);
		rd(irq_pkg::WD_CTRL_OFF, 32'h0);
		// Half the unlock sequence must not start the count
		wr(irq_pkg::WD_LOAD_OFF, 32'h40);
		wr(irq_pkg::WD_CTRL_OFF, irq_pkg::WD_KEY_FIRST);
		repeat (90) @(posedge CORE_CLK);
		#1;
		chk({31'h0, CHIP_RESET}, 32'h0);
		rd(irq_pkg::WD_CTRL_OFF, 32'h1);
		$display("reset test done");

		// Each upper source alone, alternately steered to FIQ
		for (int i = 27; i < 32; i++)
		begin
			b = 32'h1 << i;
			wr(irq_pkg::MASK_UPPER_OFF, b);
			wr(irq_pkg::STEER_UPPER_OFF, i[0] ? b : 32'h0);
			rd(irq_pkg::IRQ_PEND_UPPER_OFF, i[0] ? 32'h0 : b);
			rd(irq_pkg::FIQ_PEND_UPPER_OFF, i[0] ? b : 32'h0);
			#1;
			chk({30'h0, CORE_IRQ, CORE_FIQ}, i[0] ? 32'h1 : 32'h2);
		end
		wr(irq_pkg::MASK_UPPER_OFF, 32'h0);
		// Random lower sources; bit 0 and watchdog bit kept masked
		r = $urandom;
		m = $urandom & ~32'h2_0001;
		s = $urandom;
		SRC_LOWER <= r;
		wr(irq_pkg::MASK_LOWER_OFF, m);
		wr(irq_pkg::STEER_LOWER_OFF, s);
		rd(irq_pkg::IRQ_PEND_LOWER_OFF, r & m & ~s);
		rd(irq_pkg::FIQ_PEND_LOWER_OFF, r & m & s);
		wr(irq_pkg::PRIO_UPPER_OFF, 32'hC);
		rd(irq_pkg::PRIO_UPPER_OFF, 32'hC);
		rd(8'h3C, 32'h0);
		$display("mask test done");

		SRC_LOWER <= 32'h0;
		wr(irq_pkg::MASK_LOWER_OFF, 32'h0);
		wr(irq_pkg::WD_CTRL_OFF, irq_pkg::WD_KEY_SECOND);
		wt(1'b0, 1'b1);
		chk({30'h0, CORE_IRQ, CORE_FIQ}, 32'h0);
		for (k = 0; k < 40 && CHIP_RESET === 1'b1; k++)
		begin
			@(posedge CORE_CLK);
			#1;
		end
		chk(32'(k), 32'(irq_pkg::CHIP_RESET_CYCLES));
		// Interrupt outcome, steered to FIQ; keys restart the count
		f0 = fiq_n;
		i0 = irq_n;
		wr(irq_pkg::MASK_LOWER_OFF, 32'h2_0000);
		wr(irq_pkg::STEER_LOWER_OFF, 32'h2_0000);
		wr(irq_pkg::WD_CTRL_OFF, irq_pkg::WD_KEY_FIRST);
		wr(irq_pkg::WD_CTRL_OFF, irq_pkg::WD_KEY_SECOND);
		wt(1'b1, 1'b1);
		chk({31'h0, CHIP_RESET}, 32'h0);
		repeat (3) @(posedge CORE_CLK);
		chk(32'(fiq_n - f0), 32'h1);
		chk(32'(irq_n - i0), 32'h0);
		rd(irq_pkg::FIQ_PEND_LOWER_OFF, 32'h2_0000);
		rd(irq_pkg::IRQ_PEND_LOWER_OFF, 32'h0);
		wr(irq_pkg::WD_LOAD_OFF, 32'hFFFF);
		wr(irq_pkg::WD_CTRL_OFF, 32'h0);
		rd(irq_pkg::EVT_STATUS_OFF, 32'h3);
		wr(irq_pkg::FIQ_PEND_LOWER_OFF, 32'h2_0000);
		rd(irq_pkg::FIQ_PEND_LOWER_OFF, 32'h0);
		wt(1'b1, 1'b0);
		$display("watchdog test done");

		// Event interrupt raised, masked and cleared
		wr(irq_pkg::EVT_MASK_OFF, 32'h1);
		#1;
		chk({31'h0, EVENT_IRQ}, 32'h1);
		wr(irq_pkg::EVT_MASK_OFF, 32'h0);
		#1;
		chk({31'h0, EVENT_IRQ}, 32'h0);
		wr(irq_pkg::EVT_MASK_OFF, 32'h3);
		wr(irq_pkg::EVT_STATUS_OFF, 32'h3);
		rd(irq_pkg::EVT_STATUS_OFF, 32'h0);
		#1;
		chk({31'h0, EVENT_IRQ}, 32'h0);
		$display("event test done");
		print_verdict;
	end
endmodule
